//--- gated_sixteen_bit_timer.sv
// gated sixteen-bit timer with wishbone register access
`include "gate_timer_params.svh"

module gated_sixteen_bit_timer #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // classic wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // pins and sibling sources
  input  wire logic              ext_clock_pin,
  input  wire logic              gate_pin,
  input  wire logic              byte_timer_wrap,
  input  wire logic              period_timer_reset,
  input  wire logic              watchdog_overflow,
  input  wire logic              watchdog_enable_cfg,
  // outputs to the system
  output logic                   overflow_irq_flag,
  output logic                   watchdog_run,
  output logic                   watchdog_reset_req
);

  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_addr_w_check
    $error("ADDR_W must be 5 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [15:0] count_r;
  logic [7:0]  timer_control_reg;
  logic [7:0]  gate_control_reg;
  logic [7:0]  option_r;
  logic        ovf_flag_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        gate_level;

  wire logic       bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic       wr_req   = bus_req & wb_we_i & wb_sel_i[0];
  wire logic [7:0] adr8     = 8'(wb_adr_i);
  wire logic       wr_low   = wr_req & (adr8 == `GT_ADDR_COUNT_LOW);
  wire logic       wr_high  = wr_req & (adr8 == `GT_ADDR_COUNT_HIGH);
  wire logic       wr_ctrl  = wr_req & (adr8 == `GT_ADDR_TIMER_CTRL);
  wire logic       wr_gctl  = wr_req & (adr8 == `GT_ADDR_GATE_CTRL);
  wire logic       wr_stat  = wr_req & (adr8 == `GT_ADDR_STATUS);
  wire logic       wr_opt   = wr_req & (adr8 == `GT_ADDR_OPTION);
  wire logic       cnt_wr   = wr_low | wr_high;

  // one wait-free ack per request, dropped the cycle after
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // read data is the count as it stands in the system domain, so a read never
  // sees a half-updated value even when counting from the pin
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (bus_req)
    begin
      if (adr8 == `GT_ADDR_COUNT_LOW)
        rdata_r <= {24'h0, count_r[7:0]};
      else if (adr8 == `GT_ADDR_COUNT_HIGH)
        rdata_r <= {24'h0, count_r[15:8]};
      else if (adr8 == `GT_ADDR_TIMER_CTRL)
        rdata_r <= {24'h0, timer_control_reg & 8'hF5};
      else if (adr8 == `GT_ADDR_GATE_CTRL)
        rdata_r <= {24'h0, gate_control_reg[7:3], gate_level, gate_control_reg[1:0]};
      else if (adr8 == `GT_ADDR_STATUS)
        rdata_r <= {30'h0, watchdog_run, ovf_flag_r};
      else if (adr8 == `GT_ADDR_OPTION)
        rdata_r <= {24'h0, option_r};
      else
        rdata_r <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      timer_control_reg <= `GT_CTRL_RESET;
    else if (wr_ctrl)
      timer_control_reg <= wb_dat_i[7:0] & 8'hF5;
  end

  // bits 5:3 of gate control are held storage only; bit 2 reads live gate level
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      gate_control_reg <= `GT_GCTL_RESET;
    else if (wr_gctl)
      gate_control_reg <= wb_dat_i[7:0] & 8'hFB;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      option_r <= `GT_OPT_RESET;
    else if (wr_opt)
      option_r <= wb_dat_i[7:0] & 8'h0F;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control decode

  wire logic       timer_on  = timer_control_reg[`GT_CTRL_ON_BIT];
  wire logic       sync_dis  = timer_control_reg[`GT_CTRL_SYNC_DIS];
  wire logic [1:0] ps_sel    = timer_control_reg[`GT_CTRL_PS_LSB +: 2];
  wire logic [1:0] cs_field  = timer_control_reg[`GT_CTRL_CS_LSB +: 2];
  wire logic       gate_en   = gate_control_reg[`GT_GCTL_GE];
  wire logic       gate_pol  = gate_control_reg[`GT_GCTL_POL];
  wire logic [1:0] gs_field  = gate_control_reg[`GT_GCTL_SS_LSB +: 2];
  wire logic       ext_sel   = (cs_field == gate_timer_pkg::CS_EXT_PIN);

  ////////////////////////////////////////////////////////////////////////////
  // gate selection

  // sibling pulses are already one-cycle low-to-high pulses in this domain
  always_comb
  begin
    case (gate_timer_pkg::gate_source_e'(gs_field))
      gate_timer_pkg::GS_PIN:      gate_level = gate_pin;
      gate_timer_pkg::GS_BYTE_OVF: gate_level = byte_timer_wrap;
      gate_timer_pkg::GS_PERIOD:   gate_level = period_timer_reset;
      default:                     gate_level = watchdog_overflow;
    endcase
  end

  // watchdog powers up for gating even with the timer off; no reset follows
  assign watchdog_run = watchdog_enable_cfg | (gate_en & (gs_field == 2'h3));
  assign watchdog_reset_req = watchdog_enable_cfg & watchdog_overflow;

  wire logic gate_open = ~gate_en | (gate_level == gate_pol);
  wire logic run       = timer_on & gate_open;

  ////////////////////////////////////////////////////////////////////////////
  // clock source and external edge handling

  logic [1:0] instr_div_r;
  logic       pin_d_r;
  logic       pin_sync1_r;
  logic       pin_sync2_r;
  logic       pin_sync3_r;
  gate_timer_pkg::arm_state_e arm_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      instr_div_r <= 2'h0;
    else
      instr_div_r <= instr_div_r + 2'h1;
  end

  wire logic instr_tick = (instr_div_r == 2'(`GT_INSTR_DIV - 1));

  // no-sync path: pin is taken directly, one register for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pin_d_r <= 1'b0;
    else
      pin_d_r <= ext_clock_pin;
  end

  // sync path: two flops, then a third for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_sync1_r <= 1'b0;
      pin_sync2_r <= 1'b0;
      pin_sync3_r <= 1'b0;
    end
    else
    begin
      pin_sync1_r <= ext_clock_pin;
      pin_sync2_r <= pin_sync1_r;
      pin_sync3_r <= pin_sync2_r;
    end
  end

  // switching paths mid-edge may drop or add one increment, which is accepted
  wire logic pin_now  = sync_dis ? pin_d_r : pin_sync3_r;
  wire logic pin_prev = sync_dis ? ext_clock_pin : pin_sync2_r;
  wire logic pin_rise = ~pin_now & pin_prev;
  wire logic pin_fall = pin_now & ~pin_prev;

  // rearm on reset, count write, or while the timer is off
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      arm_r <= gate_timer_pkg::ARM_WAIT_LOW;
    else
    begin
      case (arm_r)
        gate_timer_pkg::ARM_WAIT_LOW:
          if (pin_fall && timer_on && !cnt_wr)
            arm_r <= gate_timer_pkg::ARM_READY;
        gate_timer_pkg::ARM_READY:
          if (cnt_wr || !timer_on)
            arm_r <= gate_timer_pkg::ARM_WAIT_LOW;
        default:
          arm_r <= gate_timer_pkg::ARM_WAIT_LOW;
      endcase
    end
  end

  logic src_tick;

  always_comb
  begin
    case (gate_timer_pkg::clock_source_e'(cs_field))
      gate_timer_pkg::CS_INSTR:   src_tick = instr_tick;
      gate_timer_pkg::CS_SYSTEM:  src_tick = 1'b1;
      gate_timer_pkg::CS_EXT_PIN: src_tick = pin_rise & (arm_r == gate_timer_pkg::ARM_READY);
      default:                    src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter

  logic [2:0] presc_r;
  logic       presc_out;

  // terminal count mask per select: 0, 1, 3, 7
  always_comb
  begin
    case (ps_sel)
      2'h0:    presc_out = 1'b1;
      2'h1:    presc_out = (presc_r[0] == 1'b1);
      2'h2:    presc_out = (presc_r[1:0] == 2'h3);
      default: presc_out = (presc_r == 3'h7);
    endcase
  end

  wire logic src_en = run & src_tick;
  wire logic inc    = src_en & presc_out;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      presc_r <= 3'h0;
    else if (cnt_wr)
      presc_r <= 3'h0;
    else if (inc)
      presc_r <= 3'h0;
    else if (src_en)
      presc_r <= presc_r + 3'h1;
  end

  // a byte write takes the live count; the other byte keeps its value
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      count_r <= 16'h0;
    else if (wr_low)
      count_r <= {count_r[15:8], wb_dat_i[7:0]};
    else if (wr_high)
      count_r <= {wb_dat_i[7:0], count_r[7:0]};
    else if (inc)
      count_r <= count_r + 16'h1;
  end

  wire logic rollover = inc & ~cnt_wr & (count_r == 16'hFFFF);

  // set wins over a clear written in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ovf_flag_r <= 1'b0;
    else if (rollover)
      ovf_flag_r <= 1'b1;
    else if (wr_stat && !wb_dat_i[`GT_STAT_OVF])
      ovf_flag_r <= 1'b0;
  end

  assign overflow_irq_flag = ovf_flag_r;

  // the rate field and assignment bit live here only; they are decoded but not handed
  // to the watchdog or byte timer through any port; their ratios follow the shared table
  logic [8:0] byte_rate;
  logic [7:0] wdt_rate;
  logic [8:0] byte_ratio;
  logic [7:0] wdt_ratio;

  always_comb
  begin
    case (option_r[`GT_OPT_PS_LSB +: 3])
      3'h0:
      begin
        byte_rate = 9'h002;
        wdt_rate  = 8'h01;
      end
      3'h1:
      begin
        byte_rate = 9'h004;
        wdt_rate  = 8'h02;
      end
      3'h2:
      begin
        byte_rate = 9'h008;
        wdt_rate  = 8'h04;
      end
      3'h3:
      begin
        byte_rate = 9'h010;
        wdt_rate  = 8'h08;
      end
      3'h4:
      begin
        byte_rate = 9'h020;
        wdt_rate  = 8'h10;
      end
      3'h5:
      begin
        byte_rate = 9'h040;
        wdt_rate  = 8'h20;
      end
      3'h6:
      begin
        byte_rate = 9'h080;
        wdt_rate  = 8'h40;
      end
      default:
      begin
        byte_rate = 9'h100;
        wdt_rate  = 8'h80;
      end
    endcase
  end

  // only one side owns the prescaler; the other runs at 1:1
  assign byte_ratio = option_r[`GT_OPT_PSA] ? 9'h001 : byte_rate;
  assign wdt_ratio  = option_r[`GT_OPT_PSA] ? wdt_rate : 8'h01;
  wire logic unused_opt = ^{byte_ratio, wdt_ratio} | ext_sel;

endmodule : gated_sixteen_bit_timer

//--- gate_timer_params.svh
// offsets, field positions, reset values and timing counts of the gated sixteen-bit timer
`ifndef GATE_TIMER_PARAMS_SVH
`define GATE_TIMER_PARAMS_SVH

// word byte addresses
`define GT_ADDR_COUNT_LOW   8'h00
`define GT_ADDR_COUNT_HIGH  8'h04
`define GT_ADDR_TIMER_CTRL  8'h08
`define GT_ADDR_GATE_CTRL   8'h0C
`define GT_ADDR_STATUS      8'h10
`define GT_ADDR_OPTION      8'h14

// timer_control_reg fields
`define GT_CTRL_ON_BIT      0
`define GT_CTRL_SYNC_DIS    2
`define GT_CTRL_PS_LSB      4
`define GT_CTRL_CS_LSB      6

// gate_control_reg fields
`define GT_GCTL_SS_LSB      0
`define GT_GCTL_GVAL        2
`define GT_GCTL_POL         6
`define GT_GCTL_GE          7

// option fields: prescaler rate and assignment
`define GT_OPT_PS_LSB       0
`define GT_OPT_PSA          3

// status fields
`define GT_STAT_OVF         0
`define GT_STAT_WDT_RUN     1

`define GT_CTRL_RESET       8'h00
`define GT_GCTL_RESET       8'h00
`define GT_OPT_RESET        8'h0F

// instruction clock is the system clock divided by four
`define GT_INSTR_DIV        4

`endif

//--- gate_timer_pkg.sv
// types shared by the gated sixteen-bit timer
package gate_timer_pkg;

  typedef enum logic [1:0] {
    CS_INSTR    = 2'h0,
    CS_SYSTEM   = 2'h1,
    CS_EXT_PIN  = 2'h2,
    CS_RESERVED = 2'h3
  } clock_source_e;

  typedef enum logic [1:0] {
    GS_PIN       = 2'h0,
    GS_BYTE_OVF  = 2'h1,
    GS_PERIOD    = 2'h2,
    GS_WATCHDOG  = 2'h3
  } gate_source_e;

  // external-edge arming: first rising edge counts only after a falling one
  typedef enum logic [1:0] {
    ARM_WAIT_LOW = 2'b01,
    ARM_READY    = 2'b10
  } arm_state_e;

endpackage : gate_timer_pkg

//--- gate_timer_properties.sv
// port-level assertions for the gated sixteen-bit timer
`include "gate_timer_params.svh"

module gate_timer_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              watchdog_overflow,
  input wire logic              watchdog_enable_cfg,
  input wire logic              overflow_irq_flag,
  input wire logic              watchdog_run,
  input wire logic              watchdog_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrl_r;
  logic [7:0] gctl_r;
  logic       take;
  logic       rdack;
  // shadows follow the accepted writes, so reads can be judged
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rdack = wb_ack_o && !wb_we_i;
  always_ff @(posedge sys_clk)
    if (!rst_n)
      ctrl_r <= 8'h00;
    else if (take && wb_adr_i == `GT_ADDR_TIMER_CTRL)
      ctrl_r <= wb_dat_i[7:0] & 8'hF5;
  always_ff @(posedge sys_clk)
    if (!rst_n)
      gctl_r <= 8'h00;
    else if (take && wb_adr_i == `GT_ADDR_GATE_CTRL)
      gctl_r <= wb_dat_i[7:0];
  //////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  wd_run_a: assert property (watchdog_run == (watchdog_enable_cfg ||
    gctl_r[`GT_GCTL_GE] && gctl_r[`GT_GCTL_SS_LSB +: 2] == 2'h3))
    else $error("watchdog run wrong");
  wd_reset_a: assert property (watchdog_reset_req ==
    (watchdog_enable_cfg && watchdog_overflow))
    else $error("watchdog reset request wrong");
  ovf_clear_a: assert property ($fell(overflow_irq_flag) |->
    $past(take && wb_adr_i == `GT_ADDR_STATUS && !wb_dat_i[0]))
    else $error("overflow flag cleared without write");
  off_hold_a: assert property (!ctrl_r[0] && !$past(ctrl_r[0])
    |-> !$rose(overflow_irq_flag))
    else $error("stopped counter overflowed");
  stat_read_a: assert property (rdack && wb_adr_i == `GT_ADDR_STATUS
    |-> wb_dat_o[1:0] == {$past(watchdog_run), $past(overflow_irq_flag)})
    else $error("status read wrong");
  ctrl_read_a: assert property (rdack && wb_adr_i == `GT_ADDR_TIMER_CTRL
    |-> wb_dat_o[7:0] == ctrl_r)
    else $error("control read wrong");
  hi_zero_a: assert property (rdack |-> wb_dat_o[31:8] == 24'h0)
    else $error("read upper bits not zero");
endmodule : gate_timer_properties

bind gated_sixteen_bit_timer gate_timer_properties #(.ADDR_W(ADDR_W)) chk (.sys_clk,
  .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .watchdog_overflow, .watchdog_enable_cfg, .overflow_irq_flag, .watchdog_run,
  .watchdog_reset_req);

//--- gate_timer_partner.sv
// far side model: external counting clock, gate pin and sibling timer pulses
module gate_timer_partner (
  input  wire logic sys_clk,
  output logic      ext_clock_pin,
  output logic      gate_pin,
  output logic      byte_timer_wrap,
  output logic      period_timer_reset,
  output logic      watchdog_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idle = 4'h0;
  logic [3:0] act = 4'h0;
  logic       ext = 1'h0;
  assign {watchdog_overflow, period_timer_reset, byte_timer_wrap, gate_pin} = idle ^ act;
  // clock stands low between bursts
  assign ext_clock_pin = ext;
  // one-cycle pulses, as the siblings give on wrap and period reset
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      act <= m;
      @(posedge sys_clk);
      act <= 4'h0;
    end
  endtask : pulse
  task automatic clock(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      ext <= 1'h1;
      repeat (4) @(posedge sys_clk);
      ext <= 1'h0;
      repeat (3) @(posedge sys_clk);
    end
  endtask : clock
endmodule : gate_timer_partner

//--- gated_sixteen_bit_timer_test.sv
// self-checking bench for the gated sixteen-bit timer
`include "gate_timer_params.svh"

module gated_sixteen_bit_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        watchdog_enable_cfg = 1'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, overflow_irq_flag, watchdog_run, watchdog_reset_req;
  logic        ext_clock_pin, gate_pin, byte_timer_wrap, period_timer_reset, watchdog_overflow;
  logic [31:0] seed = 32'h99D4;
  logic [8:0]  exp_q [$];
  logic [8:0]  e;
  int          num_errors = 0;
  int          samples_checked = 0;
  // control value and expected low count after 96 edges
  logic [15:0] tbl [10] = '{16'h4160, 16'h5130, 16'h6118, 16'h710C, 16'h0118,
                            16'h110C, 16'h2106, 16'h3103, 16'hC100, 16'h4000};
  // gate control, pulse mask, idle levels
  logic [15:0] gt [5] = '{16'hC010, 16'h8011, 16'hC120, 16'hC240, 16'hC380};

  gated_sixteen_bit_timer #(.ADDR_W(8)) uut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_clock_pin,
    .gate_pin, .byte_timer_wrap, .period_timer_reset, .watchdog_overflow,
    .watchdog_enable_cfg, .overflow_irq_flag, .watchdog_run, .watchdog_reset_req);
  gate_timer_partner partner (.sys_clk, .ext_clock_pin, .gate_pin, .byte_timer_wrap,
    .period_timer_reset, .watchdog_overflow);

  always #4 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, 24'h0, d};
    repeat (20) if (wb_ack_o !== 1'h1) @(posedge sys_clk);
    if (wb_ack_o !== 1'h1)
    begin
      num_errors++;
      $display("ERROR ack: expected 1 seen %b", wb_ack_o);
    end
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : req
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req(1'h1, a, d, 4'hF);
  endtask : wr
  // top bit of the note allows one count of slack for prescaler phase
  task automatic rd(input logic [7:0] a, input logic [8:0] x);
    exp_q.push_back(x);
    req(1'h0, a, 8'h00, 4'hF);
  endtask : rd
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  //////////////////////////////////////////////////
  always @(posedge sys_clk)
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      samples_checked++;
      if (wb_dat_o !== {24'h0, e[7:0]} && !(e[8] && (wb_dat_o === {24'h0, e[7:0] + 8'h1}
          || wb_dat_o === {24'h0, e[7:0] - 8'h1})))
      begin
        num_errors++;
        $display("ERROR read data: expected %h seen %h", e[7:0], wb_dat_o);
      end
    end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(`GT_ADDR_TIMER_CTRL, 9'h000);
    rd(`GT_ADDR_OPTION, 9'h00F);
    rd(`GT_ADDR_STATUS, 9'h000);
    rd(8'h18, 9'h000);
    seed = xs(seed);
    wr(`GT_ADDR_OPTION, seed[15:8]);
    rd(`GT_ADDR_OPTION, {5'h00, seed[11:8]});
    wr(`GT_ADDR_TIMER_CTRL, 8'hCA);
    rd(`GT_ADDR_TIMER_CTRL, 9'h0C0);
    seed = xs(seed);
    wr(`GT_ADDR_COUNT_LOW, seed[7:0]);
    wr(`GT_ADDR_COUNT_HIGH, 8'h12);
    req(1'h1, `GT_ADDR_COUNT_HIGH, 8'h34, 4'hE);
    rd(`GT_ADDR_COUNT_LOW, {1'h0, seed[7:0]});
    rd(`GT_ADDR_COUNT_HIGH, 9'h012);
    foreach (tbl[i])
    begin
      wr(`GT_ADDR_COUNT_LOW, 8'h00);
      wr(`GT_ADDR_TIMER_CTRL, tbl[i][15:8]);
      repeat (93) @(posedge sys_clk);
      wr(`GT_ADDR_TIMER_CTRL, 8'h00);
      rd(`GT_ADDR_COUNT_LOW, {1'h0, tbl[i][7:0]});
    end
    wr(`GT_ADDR_COUNT_HIGH, 8'hFF);
    wr(`GT_ADDR_COUNT_LOW, 8'hFF);
    wr(`GT_ADDR_TIMER_CTRL, 8'h41);
    repeat (8) @(posedge sys_clk);
    wr(`GT_ADDR_TIMER_CTRL, 8'h00);
    rd(`GT_ADDR_COUNT_HIGH, 9'h000);
    rd(`GT_ADDR_STATUS, 9'h001);
    wr(`GT_ADDR_STATUS, 8'h00);
    rd(`GT_ADDR_STATUS, 9'h000);
    foreach (gt[i])
    begin
      seed = xs(seed);
      watchdog_enable_cfg <= seed[0];
      partner.idle <= gt[i][3:0];
      wr(`GT_ADDR_GATE_CTRL, gt[i][15:8]);
      rd(`GT_ADDR_GATE_CTRL, {1'h0, gt[i][15:11], gt[i][gt[i][9:8]], gt[i][9:8]});
      wr(`GT_ADDR_COUNT_LOW, 8'h00);
      wr(`GT_ADDR_TIMER_CTRL, 8'h41);
      partner.pulse(gt[i][7:4], 5);
      wr(`GT_ADDR_TIMER_CTRL, 8'h00);
      rd(`GT_ADDR_COUNT_LOW, 9'h005);
    end
    wr(`GT_ADDR_GATE_CTRL, 8'h00);
    // pin low at the write, so the first rise must be ignored
    for (int s = 0; s < 2; s++)
    begin
      wr(`GT_ADDR_COUNT_LOW, 8'h00);
      wr(`GT_ADDR_TIMER_CTRL, {5'h10, s[0], 2'h1});
      partner.clock(4);
      repeat (4) @(posedge sys_clk);
      wr(`GT_ADDR_TIMER_CTRL, 8'h00);
      rd(`GT_ADDR_COUNT_LOW, 9'h003);
    end
    results();
  end
endmodule : gated_sixteen_bit_timer_test
